// ### design/spfs_top.sv
// serial frame sequencer: word fifos, master sequencer, slave link logic
// Behaviour
// - idle with polarity zero: clock low, frame select high, transmit low
// - idle with polarity one outside command mode: clock high, frame select high, transmit low
// - clock pad enabled as master, disabled as slave
// - enabled with queued data: drop frame select, enable transmit pad
// - phase zero: first bit half period after select, first edge later
// - polarity 0 phase 0: capture rising, change falling
// - phase one: data valid and first edge half period after select
// - polarity 0 phase 1: capture falling, change rising
// - polarity 1 phase 0: first edge falling, capture falling
// - polarity 1 phase 1: capture rising, change falling
// - frame select rises one period after last captured bit
// - phase zero bursts: frame select pulses high between words
// - phase one bursts: frame select stays low until the last word
// - command mode: 8-bit control word first, input ignored meanwhile
// - queued control byte starts frame, MSB out at select fall
// - command mode: one wait clock, reply latched on rising edges
// - reply 4 to 16 bits, whole frame 13 to 25 bits
// - single command frame: select rises, reply goes to receive fifo
// - continuous command frames: select low, next control follows
// - words of 4 to 16 bits, most significant bit first
// - separate transmit and receive fifos, eight 16-bit entries each
`timescale 1ns/10ps

// -----------------------------------------------------------------
// word fifo
// -----------------------------------------------------------------
module spfs_fifo (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // filling side
  input wire logic pushValid,
  input wire logic [spfs_pkg::WORD_W-1:0] pushData,
  output logic pushReady,
  // draining side
  output logic popValid,
  output logic [spfs_pkg::WORD_W-1:0] popData,
  input wire logic popReady
);
  logic [spfs_pkg::WORD_W-1:0] mem_q [spfs_pkg::FIFO_DEPTH];
  logic [spfs_pkg::PTR_W-1:0] wrPtr_q;
  logic [spfs_pkg::PTR_W-1:0] rdPtr_q;
  logic [spfs_pkg::PTR_W:0] count_q;
  logic doPush;
  logic doPop;

  assign pushReady = (count_q != spfs_pkg::FIFO_FULL_CNT);
  assign popValid = (count_q != '0);
  assign popData = mem_q[rdPtr_q];
  assign doPush = pushValid && pushReady;
  assign doPop = popReady && popValid;

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 1'b1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  property p_fifo_bound;
    @(posedge core_clk) disable iff (!resetn)
    count_q <= spfs_pkg::FIFO_FULL_CNT && (count_q != '0 || !popValid);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo count beyond depth");
endmodule // spfs_fifo

// -----------------------------------------------------------------
// top
// -----------------------------------------------------------------
module spfs_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // configuration, change only while disabled
  input wire spfs_pkg::spfs_cfg_t cfg,
  // transmit words
  input wire logic [spfs_pkg::WORD_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  // receive words
  output logic [spfs_pkg::WORD_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  // status
  output logic busy,
  // serial pins; the clock input is the link clock in slave mode
  input wire logic serialClockPinIn,
  input wire logic framSelectPinIn,
  input wire logic serialInPin,
  output spfs_pkg::spfs_pins_t pins
);
  spfs_pkg::spfs_state_t state_q;
  logic [5:0] t_q;
  logic [3:0] halfCnt_q;
  logic cont_q;
  logic fss_q;
  logic sclkLvl_q;
  logic txBit_q;
  logic [spfs_pkg::WORD_W-1:0] txSh_q;
  logic [spfs_pkg::WORD_W-1:0] rxSh_q;
  logic [spfs_pkg::WORD_W-1:0] rxWord_q;
  logic rxPush_q;
  logic pend_q;
  logic rxSync1_q;
  logic rxSync2_q;
  logic [5:0] twoN;
  logic [5:0] lastCap;
  logic [5:0] endT;
  logic [5:0] tn;
  logic [5:0] togLo;
  logic [5:0] togHi;
  logic [5:0] rxLo;
  logic tick;
  logic spiPh1;
  logic fifoHas;
  logic [spfs_pkg::WORD_W-1:0] fifoWord;
  logic [spfs_pkg::WORD_W-1:0] justified;
  logic startNow;
  logic loopNow;
  logic txUpd;
  logic rxCap;
  logic masterPop;
  logic slavePop;
  logic slaveOn;
  logic [spfs_pkg::WORD_W-1:0] pushWord;
  logic pushNow;

  // ---------------------------------------------------------------
  // fifos
  // ---------------------------------------------------------------
  spfs_fifo u_txFifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .pushValid(txValid),
    .pushData(txData),
    .pushReady(txReady),
    .popValid(fifoHas),
    .popData(fifoWord),
    .popReady(masterPop || slavePop)
  );

  // overrun drops the word; the stream cannot stall a remote clock
  spfs_fifo u_rxFifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .pushValid(pushNow),
    .pushData(pushWord),
    .pushReady(),
    .popValid(rxValid),
    .popData(rxData),
    .popReady(rxReady)
  );

  // ---------------------------------------------------------------
  // frame timing, in half serial periods from the select fall
  // ---------------------------------------------------------------
  always_comb begin
    spiPh1 = cfg.clockPhase && !cfg.cmdMode;
    twoN = 6'({cfg.dataSize, 1'b0}) + spfs_pkg::TICK_SECOND;
    lastCap = cfg.cmdMode ? twoN + spfs_pkg::CMD_WAIT_T : twoN;
    endT = lastCap + spfs_pkg::TICK_SECOND;
    tn = t_q + spfs_pkg::TICK_FIRST;
    togLo = (spiPh1 || cont_q) ? spfs_pkg::TICK_FIRST
                               : spfs_pkg::TICK_SECOND;
    togHi = spiPh1 ? twoN : lastCap + spfs_pkg::TICK_FIRST;
    rxLo = cfg.cmdMode ? spfs_pkg::CMD_WAIT_T + spfs_pkg::TICK_SECOND
                       : spfs_pkg::TICK_SECOND;
    if (cfg.cmdMode) begin
      justified = {fifoWord[spfs_pkg::CTRL_MSB:0], 8'h00};
    end else begin
      justified = fifoWord << (spfs_pkg::WORD_MSB - cfg.dataSize);
    end
  end

  assign tick = (halfCnt_q == '0);
  assign startNow = (state_q == spfs_pkg::ST_IDLE) && cfg.enable
                    && cfg.master && fifoHas;
  // phase one and command frames chain without releasing select
  assign loopNow = (state_q == spfs_pkg::ST_RUN) && tick && (tn == lastCap)
                   && cfg.enable && fifoHas
                   && (cfg.cmdMode || cfg.clockPhase);
  assign masterPop = startNow || loopNow;
  // data changes on odd ticks, capture on even ticks
  assign txUpd = tn[0] && (cfg.cmdMode
                 ? (tn >= spfs_pkg::CMD_TX_FIRST
                    && tn <= spfs_pkg::CMD_TX_LAST)
                 : (tn < twoN));
  assign rxCap = !tn[0] && (tn >= rxLo) && (tn <= lastCap);

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= spfs_pkg::ST_IDLE;
      t_q <= spfs_pkg::TICK_ZERO;
      cont_q <= 1'b0;
    end else if (!cfg.enable || !cfg.master) begin
      state_q <= spfs_pkg::ST_IDLE;
      cont_q <= 1'b0;
    end else begin
      unique case (state_q)
        spfs_pkg::ST_IDLE: begin
          if (startNow) begin
            state_q <= spfs_pkg::ST_RUN;
            t_q <= spfs_pkg::TICK_ZERO;
            cont_q <= 1'b0;
          end
        end
        spfs_pkg::ST_RUN: begin
          if (loopNow) begin
            t_q <= spfs_pkg::TICK_ZERO;
            cont_q <= 1'b1;
          end else if (tick && tn == endT) begin
            state_q <= spfs_pkg::ST_GAP;
          end else if (tick) begin
            t_q <= tn;
          end
        end
        spfs_pkg::ST_GAP: begin
          if (tick) begin
            state_q <= spfs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      halfCnt_q <= spfs_pkg::HALF_LAST;
    end else if (state_q == spfs_pkg::ST_IDLE || tick) begin
      halfCnt_q <= spfs_pkg::HALF_LAST;
    end else begin
      halfCnt_q <= halfCnt_q - 4'h1;
    end
  end

  // pins: select, clock level, transmit bit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fss_q <= 1'b1;
      sclkLvl_q <= 1'b0;
    end else if (state_q != spfs_pkg::ST_RUN) begin
      fss_q <= !startNow;
      sclkLvl_q <= 1'b0;
    end else if (tick) begin
      if (tn == endT && !loopNow) begin
        fss_q <= 1'b1;
      end
      if (tn >= togLo && tn <= togHi) begin
        sclkLvl_q <= !sclkLvl_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txBit_q <= 1'b0;
      txSh_q <= '0;
    end else if (masterPop) begin
      if (cfg.cmdMode) begin
        txBit_q <= justified[spfs_pkg::WORD_MSB];
        txSh_q <= justified << 1;
      end else begin
        txBit_q <= 1'b0;
        txSh_q <= justified;
      end
    end else if (state_q != spfs_pkg::ST_RUN) begin
      txBit_q <= 1'b0;
    end else if (tick && txUpd) begin
      txBit_q <= txSh_q[spfs_pkg::WORD_MSB];
      txSh_q <= txSh_q << 1;
    end
  end

  // receive input is a pin: two flip-flops before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxSync1_q <= 1'b0;
      rxSync2_q <= 1'b0;
    end else begin
      rxSync1_q <= serialInPin;
      rxSync2_q <= rxSync1_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxSh_q <= '0;
      rxWord_q <= '0;
      rxPush_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      rxPush_q <= 1'b0;
      if (state_q == spfs_pkg::ST_RUN && tick) begin
        if (rxCap && tn == lastCap) begin
          rxWord_q <= {rxSh_q[spfs_pkg::WORD_MSB-1:0], rxSync2_q};
          rxSh_q <= '0;
          rxPush_q <= !cfg.cmdMode;
          pend_q <= cfg.cmdMode;
        end else if (rxCap) begin
          rxSh_q <= {rxSh_q[spfs_pkg::WORD_MSB-1:0], rxSync2_q};
        end
        // command reply moves at select rise or the next falling edge
        if (pend_q && (tn == endT || tn == spfs_pkg::TICK_FIRST)) begin
          rxPush_q <= 1'b1;
          pend_q <= 1'b0;
        end
      end else if (state_q == spfs_pkg::ST_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // slave link logic, clocked by the remote serial clock
  // ---------------------------------------------------------------
  logic sampleClk;
  logic frameRstN;
  logic [3:0] lBitCnt_q;
  logic [3:0] lTxIdx_q;
  logic [spfs_pkg::WORD_W-1:0] lRxSh_q;
  logic [spfs_pkg::WORD_W-1:0] lRxWord_q;
  logic [spfs_pkg::WORD_W-1:0] lTxWord_q;
  logic lRxTgl_q;
  logic lAckTgl_q;
  logic [spfs_pkg::WORD_W-1:0] sHold_q;
  logic sHoldFull_q;
  logic ackS1_q;
  logic ackS2_q;
  logic ackS3_q;
  logic rtS1_q;
  logic rtS2_q;
  logic rtS3_q;
  logic slaveTx;

  assign slaveOn = cfg.enable && !cfg.master && !cfg.cmdMode;
  // capture edge is rising on sampleClk; config is static while enabled
  assign sampleClk = serialClockPinIn
                     ^ (cfg.clockPolarity ^ cfg.clockPhase);
  // select high ends the frame's bit count without needing clock edges
  assign frameRstN = resetn && !framSelectPinIn && slaveOn;

  always_ff @(posedge sampleClk or negedge frameRstN) begin
    if (!frameRstN) begin
      lBitCnt_q <= '0;
      lRxSh_q <= '0;
    end else begin
      lRxSh_q <= {lRxSh_q[spfs_pkg::WORD_MSB-1:0], serialInPin};
      if (lBitCnt_q == cfg.dataSize) begin
        lBitCnt_q <= '0;
      end else begin
        lBitCnt_q <= lBitCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sampleClk or negedge resetn) begin
    if (!resetn) begin
      lRxWord_q <= '0;
      lTxWord_q <= '0;
      lRxTgl_q <= 1'b0;
      lAckTgl_q <= 1'b0;
    end else if (frameRstN) begin
      if (lBitCnt_q == cfg.dataSize) begin
        lRxWord_q <= {lRxSh_q[spfs_pkg::WORD_MSB-1:0], serialInPin};
        lRxTgl_q <= !lRxTgl_q;
      end
      if (lBitCnt_q == '0) begin
        lTxWord_q <= sHold_q;
        lAckTgl_q <= !lAckTgl_q;
      end
    end
  end

  // outgoing bit index moves on the change edge
  always_ff @(negedge sampleClk or negedge frameRstN) begin
    if (!frameRstN) begin
      lTxIdx_q <= '0;
    end else begin
      lTxIdx_q <= lBitCnt_q;
    end
  end

  // bit 0 comes straight from the holding word so phase zero has it
  // ready at the select fall
  assign slaveTx = (lTxIdx_q == '0) ? sHold_q[cfg.dataSize]
                   : lTxWord_q[cfg.dataSize - lTxIdx_q];

  // core side of the crossing: toggles through two flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ackS1_q <= 1'b0;
      ackS2_q <= 1'b0;
      ackS3_q <= 1'b0;
      rtS1_q <= 1'b0;
      rtS2_q <= 1'b0;
      rtS3_q <= 1'b0;
    end else begin
      ackS1_q <= lAckTgl_q;
      ackS2_q <= ackS1_q;
      ackS3_q <= ackS2_q;
      rtS1_q <= lRxTgl_q;
      rtS2_q <= rtS1_q;
      rtS3_q <= rtS2_q;
    end
  end

  assign slavePop = slaveOn && fifoHas
                    && (!sHoldFull_q || (ackS2_q ^ ackS3_q));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sHold_q <= '0;
      sHoldFull_q <= 1'b0;
    end else if (slavePop) begin
      sHold_q <= fifoWord;
      sHoldFull_q <= 1'b1;
    end else if (!slaveOn || (ackS2_q ^ ackS3_q)) begin
      sHoldFull_q <= 1'b0;
    end
  end

  assign pushNow = rxPush_q || (slaveOn && (rtS2_q ^ rtS3_q));
  assign pushWord = rxPush_q ? rxWord_q : lRxWord_q;

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb begin
    pins.serialClockPinOut = sclkLvl_q
                             ^ (cfg.clockPolarity && !cfg.cmdMode);
    pins.serialClockPinOe = cfg.master;
    pins.framSelectPinOut = fss_q;
    pins.framSelectPinOe = cfg.master;
    pins.serialOutPinOut = cfg.master ? txBit_q : slaveTx;
    pins.serialOutPinOe = cfg.master
                          || (slaveOn && !framSelectPinIn);
  end

  assign busy = (state_q != spfs_pkg::ST_IDLE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_fss_high_half;
    pins.framSelectPinOut [*4];
  endsequence

  property p_idle_pol0;
    @(posedge core_clk) disable iff (!resetn)
    (state_q == spfs_pkg::ST_IDLE && cfg.master && !cfg.clockPolarity)
    |-> !pins.serialClockPinOut && pins.framSelectPinOut
        && !pins.serialOutPinOut;
  endproperty
  a_idle_pol0: assert property (p_idle_pol0)
    else $error("idle levels wrong for polarity zero");

  property p_idle_pol1;
    @(posedge core_clk) disable iff (!resetn)
    (state_q == spfs_pkg::ST_IDLE && cfg.master && cfg.clockPolarity
     && !cfg.cmdMode) |-> pins.serialClockPinOut
        && pins.framSelectPinOut && !pins.serialOutPinOut;
  endproperty
  a_idle_pol1: assert property (p_idle_pol1)
    else $error("idle levels wrong for polarity one");

  property p_clk_pad;
    @(posedge core_clk) disable iff (!resetn)
    pins.serialClockPinOe == cfg.master;
  endproperty
  a_clk_pad: assert property (p_clk_pad)
    else $error("clock pad enable does not follow master");

  property p_start;
    @(posedge core_clk) disable iff (!resetn)
    startNow |=> !pins.framSelectPinOut && pins.serialOutPinOe
                 && state_q == spfs_pkg::ST_RUN;
  endproperty
  a_start: assert property (p_start)
    else $error("transfer did not start with select low");

  property p_ph0_quiet;
    @(posedge core_clk) disable iff (!resetn)
    (state_q == spfs_pkg::ST_RUN && !cfg.clockPhase && !cont_q
     && t_q < spfs_pkg::TICK_SECOND) |-> !sclkLvl_q;
  endproperty
  a_ph0_quiet: assert property (p_ph0_quiet)
    else $error("clock moved before first phase zero edge");

  property p_ph1_edge;
    @(posedge core_clk) disable iff (!resetn)
    (state_q == spfs_pkg::ST_RUN && tick && spiPh1 && !cont_q
     && tn == spfs_pkg::TICK_FIRST) |=> sclkLvl_q;
  endproperty
  a_ph1_edge: assert property (p_ph1_edge)
    else $error("phase one first edge missing");

  property p_end_select;
    @(posedge core_clk) disable iff (!resetn)
    (state_q == spfs_pkg::ST_RUN && tick && tn == endT && cfg.enable)
    |=> pins.framSelectPinOut ##1 s_fss_high_half;
  endproperty
  a_end_select: assert property (p_end_select)
    else $error("select not released one period after last bit");

  property p_ph1_hold;
    @(posedge core_clk) disable iff (!resetn)
    (loopNow && spiPh1) |=> !pins.framSelectPinOut [*4];
  endproperty
  a_ph1_hold: assert property (p_ph1_hold)
    else $error("select released between phase one words");

  property p_cmd_push;
    @(posedge core_clk) disable iff (!resetn)
    (cfg.cmdMode && cfg.master && $rose(pins.framSelectPinOut)
     && cfg.enable) |-> $past(pend_q) && rxPush_q;
  endproperty
  a_cmd_push: assert property (p_cmd_push)
    else $error("reply not moved at select rise");
endmodule // spfs_top

// ### design/spfs_pkg.sv
// package: shared types and constants of the serial frame sequencer
package spfs_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam logic [3:0] WORD_MSB = 4'hf;
  localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
  localparam logic [3:0] CTRL_MSB = 4'h7;

  // ---------------------------------------------------------------
  // timing, counted in core_clk cycles and half serial periods
  // ---------------------------------------------------------------
  localparam logic [3:0] HALF_CYC = 4'h4;
  localparam logic [3:0] HALF_LAST = HALF_CYC - 4'h1;
  localparam logic [5:0] TICK_ZERO = 6'h00;
  localparam logic [5:0] TICK_FIRST = 6'h01;
  localparam logic [5:0] TICK_SECOND = 6'h02;
  localparam logic [5:0] CMD_TX_FIRST = 6'h03;
  localparam logic [5:0] CMD_TX_LAST = 6'h11;
  localparam logic [5:0] CMD_WAIT_T = 6'h12;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_GAP
  } spfs_state_t;

  typedef struct packed {
    logic enable;
    logic master;
    logic cmdMode;
    logic clockPolarity;
    logic clockPhase;
    logic [3:0] dataSize;
  } spfs_cfg_t;

  typedef struct packed {
    logic serialClockPinOut;
    logic serialClockPinOe;
    logic framSelectPinOut;
    logic framSelectPinOe;
    logic serialOutPinOut;
    logic serialOutPinOe;
  } spfs_pins_t;

endpackage

// ### tb/spfs_far_end.sv
// far-end serial peer model for the frame sequencer bench
`timescale 1ns/10ps
module spfs_far_end (
  // link pins
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  output logic miso,
  // setup and results
  input wire spfs_pkg::spfs_cfg_t cfg,
  input wire logic [15:0] reply,
  output logic [15:0] got,
  output int words,
  output time selGap
);
  int idx = 0;
  int rc = 0;
  logic [15:0] sh = 16'h0000;
  time capT = 0;
  wire eff = sclk ^ cfg.clockPolarity ^ cfg.clockPhase;
  wire spi = !selN && !cfg.cmdMode;
  wire cmd = !selN && cfg.cmdMode;
  wire [4:0] n = cfg.dataSize + 5'h01;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    words = 0;
  end
  // no pull on the line: a released line shows its inverse level
  always @(posedge selN) begin
    miso <= ~miso;
    selGap = $time - capT;
  end
  always @(negedge selN) begin
    rc = 0;
    idx = cfg.clockPhase ? n : n - 1;
    if (!cfg.cmdMode && !cfg.clockPhase)
      miso <= reply[idx];
  end
  always @(negedge eff) if (spi) begin
    idx = (idx == 0 || idx == n) ? n - 1 : idx - 1;
    miso <= reply[idx];
  end
  always @(posedge eff) if (spi) begin
    sh = {sh[14:0], mosi};
    rc++;
    if (rc == n) begin
      got <= sh & ~(16'hffff << n);
      words++;
      rc = 0;
      capT = $time;
    end
  end
  always @(posedge sclk) if (cmd) begin
    rc++;
    if (rc <= 8)
      sh = {sh[14:0], mosi};
    if (rc == 8) begin
      got <= sh & 16'h00ff;
      words++;
    end
    if (rc == 9 + n) begin
      capT = $time;
      rc = 0;
    end
  end
  // toggling level while the port talks, so its input must be ignored
  always @(negedge sclk) if (cmd)
    miso <= (rc >= 9) ? reply[n + 8 - rc] : ~miso;
endmodule // spfs_far_end

// ### tb/spfs_tb_top.sv
// self-checking bench for the serial frame sequencer
`timescale 1ns/10ps
module spfs_tb_top;
  logic coreClk = 1'b0;
  logic resetn = 1'b0;
  spfs_pkg::spfs_cfg_t cfg = '0;
  logic [15:0] txData = 16'h0000;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic sclkIn = 1'b0;
  logic selInN = 1'b1;
  logic mosiIn = 1'b0;
  logic [15:0] reply = 16'hb3c6;
  logic [6:0] modes [6] = '{7'h03, 7'h1f, 7'h27, 7'h33, 7'h43, 7'h4f};
  logic txReady, rxValid, busy, farMiso;
  logic [15:0] rxData, got;
  spfs_pkg::spfs_pins_t pins;
  int words, fssFalls;
  int checks = 0;
  int error_cnt = 0;
  time selGap;
  wire clkLine = pins.serialClockPinOe ? pins.serialClockPinOut : sclkIn;
  wire fssLine = pins.framSelectPinOe ? pins.framSelectPinOut : selInN;
  wire dataIn = cfg.master ? farMiso : mosiIn;

  spfs_top dut_u (.core_clk(coreClk), .resetn(resetn), .cfg(cfg),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .busy(busy),
    .serialClockPinIn(clkLine), .framSelectPinIn(fssLine),
    .serialInPin(dataIn), .pins(pins));
  spfs_far_end far_u (.sclk(clkLine), .selN(fssLine),
    .mosi(pins.serialOutPinOut), .miso(farMiso), .cfg(cfg),
    .reply(reply), .got(got), .words(words), .selGap(selGap));

  always #25 coreClk = ~coreClk;
  always @(negedge fssLine) begin
    fssFalls++;
    if (cfg.master)
      chk("txOe", 16'h0001, {15'h0, pins.serialOutPinOe});
  end

  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] act);
    checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic push(logic [15:0] w);
    @(negedge coreClk);
    while (txReady !== 1'b1)
      @(negedge coreClk);
    txData = w;
    txValid = 1'b1;
    @(negedge coreClk);
    txValid = 1'b0;
  endtask
  task automatic pop(logic [15:0] exp);
    @(negedge coreClk);
    repeat (3000)
      if (rxValid !== 1'b1)
        @(negedge coreClk);
    chk("rxValid", 16'h0001, {15'h0, rxValid});
    chk("rxData", exp, rxData);
    rxReady = 1'b1;
    @(negedge coreClk);
    rxReady = 1'b0;
  endtask
  task automatic master_run(logic [6:0] md);
    logic [15:0] mask;
    int w0;
    mask = ~(16'hffff << ({1'b0, md[3:0]} + 5'h01));
    w0 = words;
    fssFalls = 0;
    cfg = {2'b01, md};
    @(negedge coreClk);
    cfg.enable = 1'b1;
    push(16'h5a69);
    push(16'ha596);
    wait_idle;
    chk("farWord", 16'ha596 & (md[6] ? 16'h00ff : mask), got);
    chk("farCount", 16'h0002, 16'(words - w0));
    chk("falls", (md[6] | md[4]) ? 16'h0001 : 16'h0002,
      16'(fssFalls));
    chk("selGap", 16'h0190, 16'(selGap));
    pop(reply & mask);
    pop(reply & mask);
    chk("idle", {12'h0, md[5], 3'b101}, {12'h0, pins.serialClockPinOut,
      pins.framSelectPinOut, pins.serialOutPinOut,
      pins.serialClockPinOe});
    cfg.enable = 1'b0;
    $display("master test %h done", md);
  endtask
  task automatic slave_run(logic [1:0] pp);
    logic [15:0] seen;
    cfg = {3'b000, pp, 4'hf};
    sclkIn = pp[1];
    push(16'hc35a);
    cfg.enable = 1'b1;
    repeat (10)
      @(negedge coreClk);
    chk("clkOe", 16'h0000, {15'h0, pins.serialClockPinOe});
    selInN = 1'b0;
    #96;
    chk("slvOe", 16'h0001, {15'h0, pins.serialOutPinOe});
    for (int i = 15; i >= 0; i--) begin
      if (pp[0])
        sclkIn = ~sclkIn;
      mosiIn = 16'h9e37 >> i;
      #24;
      seen[i] = pins.serialOutPinOut;
      sclkIn = ~sclkIn;
      #24;
      if (!pp[0])
        sclkIn = ~sclkIn;
    end
    selInN = 1'b1;
    mosiIn = ~mosiIn;
    chk("slaveTx", 16'hc35a, seen);
    pop(16'h9e37);
    cfg.enable = 1'b0;
    $display("slave test %h done", pp);
  endtask
  // busy drops for one cycle between phase zero words, so need three
  task automatic wait_idle;
    int quiet;
    quiet = 0;
    for (int i = 0; i < 3000 && quiet < 3; i++) begin
      @(negedge coreClk);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    chk("idleWait", 16'h0003, 16'(quiet));
  endtask
  task automatic fifo_run;
    int w0;
    w0 = words;
    cfg = {2'b01, 7'h13};
    repeat (8)
      push(16'h0009);
    chk("txFull", 16'h0000, {15'h0, txReady});
    fssFalls = 0;
    cfg.enable = 1'b1;
    wait_idle;
    chk("farCount", 16'h0008, 16'(words - w0));
    chk("farWord", 16'h0009, got);
    chk("falls", 16'h0001, 16'(fssFalls));
    repeat (8)
      pop(16'h0006);
    chk("rxEmpty", 16'h0000, {15'h0, rxValid});
    cfg.enable = 1'b0;
    $display("fifo test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // -------------------------------------------------------------
  // sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (16)
      @(negedge coreClk);
    resetn = 1'b1;
    foreach (modes[k])
      master_run(modes[k]);
    fifo_run;
    slave_run(2'b00);
    slave_run(2'b11);
    tally_and_finish;
  end
  initial begin
    #3000000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // spfs_tb_top
